// >>> hdl/icr_defines.vh
// Purpose: constants for the two-wire bus control register 0 block
// Assumes: 20-bit byte addresses, 8-bit registers on a plain strobe port
// Notes:   included by icr_ctrl0.v
//
// Functional notes
// - control register 0 takes single-bit or byte writes, resets to zero
// - register at F0230H, bits enable, exit, wait release, irq, wait, ack, start, stop
// - enable low stops operation, halts logic, clears the status register
// - disable also clears collision, busy flags and both line level bits
// - exit abandons transfer, enters standby, releases both lines, self-clears
// - exit clears start and stop triggers and six status flags
// - standby ends on stop detection, or address match or extension code after start
// - wait release cancels the current wait and self-clears once done
// - release at ninth-clock wait while transmitting frees data line, clears transmit
// - exit and wait release do nothing while operation is disabled
// - exit and wait release bits always read as zero
// - enabling with clock high, data low, filter on flags a start at once
// - stop detection raises the interrupt only when stop irq enable is set
// - address wakeup set suppresses the stop interrupt
`ifndef ICR_DEFINES_VH
`define ICR_DEFINES_VH

`define ICR_AW            20
`define ICR_ADDR_CTRL0    20'hF0230
`define ICR_ADDR_STATUS   20'hF0234
`define ICR_ADDR_FLAG     20'hF0238
`define ICR_ADDR_CTRL1    20'hF023C
`define ICR_ADDR_IRQST    20'hF0240
`define ICR_ADDR_IRQEN    20'hF0244
`define ICR_ADDR_IRQCLR   20'hF0248

`define ICR_CTRL0_RESET   8'h00
`define ICR_C0_ENABLE     7
`define ICR_C0_EXIT       6
`define ICR_C0_WAITREL    5
`define ICR_C0_STOPIRQ    4
`define ICR_C0_WAITPT     3
`define ICR_C0_ACK        2
`define ICR_C0_START      1
`define ICR_C0_STOP       0

`define ICR_ST_MASTER     7
`define ICR_ST_EXTCODE    6
`define ICR_ST_ADDRMATCH  5
`define ICR_ST_TRANSMIT   3
`define ICR_ST_ACKDET     2
`define ICR_ST_STARTDET   1
`define ICR_ST_STOPDET    0

`define ICR_FL_COLLISION  7
`define ICR_FL_BUSY       6

`define ICR_C1_WAKEUP     7
`define ICR_C1_CLKLEVEL   5
`define ICR_C1_DATLEVEL   4
`define ICR_C1_FILTER     2

`define ICR_IRQ_W         3
`define ICR_IRQ_STOP      0
`define ICR_IRQ_START     1
`define ICR_IRQ_ADDR      2

`endif

// >>> hdl/icr_sync.v
// Purpose: two-flop synchroniser for the bus line inputs
// Assumes: inputs are asynchronous to mclk
// Notes:   lines idle high, so flops reset to one
`timescale 1ns/1ps

module icr_sync #(
    parameter WIDTH = 2
) (
    input  wire             mclk,
    input  wire             reset_n,
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= {WIDTH{1'b1}};
            sync_r <= {WIDTH{1'b1}};
        end else begin
            meta_r <= asyncIn;
            sync_r <= meta_r;
        end
    end

    assign syncOut = sync_r;

endmodule // icr_sync

// >>> hdl/icr_ctrl0.v
// Purpose: control register 0 of the two-wire bus controller and its effects
// Assumes: protocol core outside drives the core* inputs on mclk
// Notes:   lines are open drain; oe high pulls the line low
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "icr_defines.vh"

module icr_ctrl0 (
    input  wire                 mclk,
    input  wire                 reset_n,
    input  wire [`ICR_AW-1:0]   regAddr,
    input  wire [7:0]           regWdata,
    input  wire [7:0]           regWmask,
    input  wire                 regWr,
    input  wire                 regRd,
    output wire [7:0]           regRdata,
    input  wire                 sclIn,
    output wire                 sclOut,
    output wire                 sclOe,
    input  wire                 sdaIn,
    output wire                 sdaOut,
    output wire                 sdaOe,
    input  wire                 coreSclLow,
    input  wire                 coreSdaLow,
    input  wire                 coreWait,
    input  wire                 coreNinth,
    input  wire                 coreMasterSet,
    input  wire                 coreTrcSet,
    input  wire                 coreAckDet,
    input  wire                 coreAddrMatch,
    input  wire                 coreExtCode,
    input  wire                 coreStartDone,
    input  wire                 coreStopDone,
    input  wire                 coreCollision,
    output wire                 opEnable,
    output wire                 waitPointSel,
    output wire                 ackEnable,
    output wire                 startTrig,
    output wire                 stopTrig,
    output wire                 waitCancel,
    output wire                 standby,
    output wire                 irq
);

    ////////////////////////////////////////////////////////////////////////
    // line sampling and condition detection

    wire [1:0] lineSync;
    wire       sclS;
    wire       sdaS;
    reg        en_r;
    reg        sclD_r;
    reg        sdaD_r;
    reg        enD_r;

    icr_sync #(
        .WIDTH   (2)
    ) u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .asyncIn ({sclIn, sdaIn}),
        .syncOut (lineSync)
    );

    assign sclS = lineSync[1];
    assign sdaS = lineSync[0];

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sclD_r <= 1'b1;
            sdaD_r <= 1'b1;
            enD_r  <= 1'b0;
        end else begin
            sclD_r <= sclS;
            sdaD_r <= sdaS;
            enD_r  <= en_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register state

    localparam [7:0] ctrl0Rst = `ICR_CTRL0_RESET;
    reg        wrel_r;
    reg        spie_r;
    reg        wtim_r;
    reg        acke_r;
    reg        stt_r;
    reg        spt_r;
    reg [7:0]  status_r;
    reg        stcf_r;
    reg        busy_r;
    reg        wup_r;
    reg        dfc_r;
    reg        cld_r;
    reg        dad_r;
    reg        standby_r;
    reg        sdaRel_r;
    reg [`ICR_IRQ_W-1:0] irqSt_r;
    reg [`ICR_IRQ_W-1:0] irqEn_r;
    reg        irq_r;
    reg [7:0]  rdata_r;
    reg        sclOe_r;
    reg        sdaOe_r;
    reg        waitCancel_r;

    wire       wrC0   = regWr && (regAddr == `ICR_ADDR_CTRL0);
    wire       wrC1   = regWr && (regAddr == `ICR_ADDR_CTRL1);
    wire       wrIen  = regWr && (regAddr == `ICR_ADDR_IRQEN);
    wire       wrIclr = regWr && (regAddr == `ICR_ADDR_IRQCLR);
    wire [7:0] mset   = regWdata & regWmask;

    // bit-wise merge gives single-bit and byte writes the same path
    wire [7:0] c0Cur  = {en_r, 2'b00, spie_r, wtim_r, acke_r, stt_r, spt_r};
    wire [7:0] c0New  = (c0Cur & ~regWmask) | mset;

    wire startEv  = en_r & sclS & sclD_r & sdaD_r & ~sdaS;
    wire stopEv   = en_r & sclS & sclD_r & ~sdaD_r & sdaS;
    wire spurious = en_r & ~enD_r & dfc_r & sclS & ~sdaS;
    wire startDet = startEv | spurious;

    wire exitGo   = wrC0 & mset[`ICR_C0_EXIT] & en_r;
    wire wrelSet  = wrC0 & mset[`ICR_C0_WAITREL] & en_r;
    wire wrelDo   = wrel_r & coreWait;
    wire ninthRel = wrelDo & coreNinth & status_r[`ICR_ST_TRANSMIT];
    wire wakeEv   = (coreAddrMatch | coreExtCode) & status_r[`ICR_ST_STARTDET];

    ////////////////////////////////////////////////////////////////////////
    // control register 0

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            en_r   <= ctrl0Rst[`ICR_C0_ENABLE];
            spie_r <= ctrl0Rst[`ICR_C0_STOPIRQ];
            wtim_r <= ctrl0Rst[`ICR_C0_WAITPT];
            acke_r <= ctrl0Rst[`ICR_C0_ACK];
            stt_r  <= ctrl0Rst[`ICR_C0_START];
            spt_r  <= ctrl0Rst[`ICR_C0_STOP];
            wrel_r <= 1'b0;
        end else begin
            if (wrC0) begin
                en_r   <= c0New[`ICR_C0_ENABLE];
                spie_r <= c0New[`ICR_C0_STOPIRQ];
                wtim_r <= c0New[`ICR_C0_WAITPT];
                acke_r <= c0New[`ICR_C0_ACK];
            end
            if (!en_r || exitGo) begin
                stt_r <= 1'b0;
                spt_r <= 1'b0;
            end else begin
                if (wrC0 && regWmask[`ICR_C0_START])
                    stt_r <= regWdata[`ICR_C0_START];
                else if (coreStartDone)
                    stt_r <= 1'b0;
                if (wrC0 && regWmask[`ICR_C0_STOP])
                    spt_r <= regWdata[`ICR_C0_STOP];
                else if (coreStopDone)
                    spt_r <= 1'b0;
            end
            if (!en_r)
                wrel_r <= 1'b0;
            else if (wrelSet)
                wrel_r <= 1'b1;
            else if (wrelDo)
                wrel_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status, flags, standby

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status_r  <= 8'h00;
            stcf_r    <= 1'b0;
            busy_r    <= 1'b0;
            standby_r <= 1'b0;
            sdaRel_r  <= 1'b0;
        end else if (!en_r) begin
            status_r  <= 8'h00;
            stcf_r    <= 1'b0;
            busy_r    <= 1'b0;
            standby_r <= 1'b0;
            sdaRel_r  <= 1'b0;
        end else begin
            if (exitGo) begin
                status_r[7:1] <= 7'h00;
            end else begin
                if (coreMasterSet)
                    status_r[`ICR_ST_MASTER] <= 1'b1;
                if (coreExtCode)
                    status_r[`ICR_ST_EXTCODE] <= 1'b1;
                if (coreAddrMatch)
                    status_r[`ICR_ST_ADDRMATCH] <= 1'b1;
                if (ninthRel)
                    status_r[`ICR_ST_TRANSMIT] <= 1'b0;
                else if (coreTrcSet)
                    status_r[`ICR_ST_TRANSMIT] <= 1'b1;
                if (coreAckDet)
                    status_r[`ICR_ST_ACKDET] <= 1'b1;
                if (startDet)
                    status_r[`ICR_ST_STARTDET] <= 1'b1;
            end
            if (startDet)
                status_r[`ICR_ST_STOPDET] <= 1'b0;
            else if (stopEv)
                status_r[`ICR_ST_STOPDET] <= 1'b1;
            if (coreCollision)
                stcf_r <= 1'b1;
            if (startDet)
                busy_r <= 1'b1;
            else if (stopEv)
                busy_r <= 1'b0;
            if (exitGo)
                standby_r <= 1'b1;
            else if (stopEv || wakeEv)
                standby_r <= 1'b0;
            if (ninthRel)
                sdaRel_r <= 1'b1;
            else if (!coreNinth)
                sdaRel_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register 1 and line levels

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wup_r <= 1'b0;
            dfc_r <= 1'b0;
            cld_r <= 1'b0;
            dad_r <= 1'b0;
        end else begin
            if (wrC1 && regWmask[`ICR_C1_WAKEUP])
                wup_r <= regWdata[`ICR_C1_WAKEUP];
            if (wrC1 && regWmask[`ICR_C1_FILTER])
                dfc_r <= regWdata[`ICR_C1_FILTER];
            cld_r <= (wrC0 ? c0New[`ICR_C0_ENABLE] : en_r) & sclS;
            dad_r <= (wrC0 ? c0New[`ICR_C0_ENABLE] : en_r) & sdaS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sclOe_r      <= 1'b0;
            sdaOe_r      <= 1'b0;
            waitCancel_r <= 1'b0;
        end else begin
            sclOe_r      <= en_r & ~standby_r & ~exitGo & coreSclLow;
            sdaOe_r      <= en_r & ~standby_r & ~exitGo & coreSdaLow
                            & ~sdaRel_r & ~ninthRel;
            waitCancel_r <= en_r & wrelDo;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, enable, clear

    wire [`ICR_IRQ_W-1:0] irqSet;
    wire [`ICR_IRQ_W-1:0] irqClr;
    wire [`ICR_IRQ_W-1:0] irqStNxt;
    wire [`ICR_IRQ_W-1:0] irqEnNxt;

    assign irqSet[`ICR_IRQ_STOP]  = stopEv & spie_r & ~wup_r;
    assign irqSet[`ICR_IRQ_START] = startDet;
    assign irqSet[`ICR_IRQ_ADDR]  = en_r & coreAddrMatch;
    assign irqClr   = wrIclr ? mset[`ICR_IRQ_W-1:0] : {`ICR_IRQ_W{1'b0}};
    assign irqStNxt = (irqSt_r & ~irqClr) | irqSet;
    assign irqEnNxt = wrIen ? ((irqEn_r & ~regWmask[`ICR_IRQ_W-1:0])
                              | mset[`ICR_IRQ_W-1:0]) : irqEn_r;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irqSt_r <= {`ICR_IRQ_W{1'b0}};
            irqEn_r <= {`ICR_IRQ_W{1'b0}};
            irq_r   <= 1'b0;
        end else begin
            irqSt_r <= irqStNxt;
            irqEn_r <= irqEnNxt;
            irq_r   <= |(irqStNxt & irqEnNxt);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port

    reg [7:0] rdMux;

    always @* begin
        rdMux = 8'h00;
        case (regAddr)
            `ICR_ADDR_CTRL0:  rdMux = c0Cur;
            `ICR_ADDR_STATUS: rdMux = status_r & {8{en_r}};
            `ICR_ADDR_FLAG:   rdMux = {stcf_r & en_r, busy_r & en_r, 6'h00};
            `ICR_ADDR_CTRL1:  rdMux = {wup_r, 1'b0, cld_r, dad_r, 1'b0, dfc_r, 2'b00};
            `ICR_ADDR_IRQST:  rdMux = {5'h00, irqSt_r};
            `ICR_ADDR_IRQEN:  rdMux = {5'h00, irqEn_r};
            default:          rdMux = 8'h00;
        endcase
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            rdata_r <= 8'h00;
        else
            rdata_r <= regRd ? rdMux : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    reg zero_r;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            zero_r <= 1'b0;
        else
            zero_r <= 1'b0;
    end

    assign regRdata     = rdata_r;
    assign sclOut       = zero_r;
    assign sdaOut       = zero_r;
    assign sclOe        = sclOe_r;
    assign sdaOe        = sdaOe_r;
    assign opEnable     = en_r;
    assign waitPointSel = wtim_r;
    assign ackEnable    = acke_r;
    assign startTrig    = stt_r;
    assign stopTrig     = spt_r;
    assign waitCancel   = waitCancel_r;
    assign standby      = standby_r;
    assign irq          = irq_r;

endmodule // icr_ctrl0

// >>> verification/icr_bus_model.sv
// Purpose: far side of the two-wire bus
// Assumes: open-drain lines with pull-ups, 100 ns between line edges
// Notes:   lines move only inside start and stop framing, or through holdSda on the data line
`timescale 1ns/1ps

module icr_bus_model (
    input  wire sclOe,
    input  wire sdaOe,
    output wire sclIn,
    output wire sdaIn
);
    reg mScl = 1'b1;
    reg mSda = 1'b1;

    // a released line is pulled high
    assign sclIn = mScl & ~sclOe;
    assign sdaIn = mSda & ~sdaOe;

    task genStart;
        begin
            mSda = 1'b1;
            mScl = 1'b1;
            #100 mSda = 1'b0;
            #100 mScl = 1'b0;
            #100;
        end
    endtask

    task genStop;
        begin
            mSda = 1'b0;
            #100 mScl = 1'b1;
            #100 mSda = 1'b1;
            #100;
        end
    endtask

    task holdSda(input v);
        mSda = v;
    endtask
endmodule // icr_bus_model

// >>> verification/icr_ctrl0_monitor.sv
// Purpose: port checker for icr_ctrl0
// Assumes: one clock domain, async low reset
// Notes:   bound to every icr_ctrl0
`timescale 1ns/1ps
`include "icr_defines.vh"

module icr_ctrl0_monitor (
    input wire               mclk,
    input wire               reset_n,
    input wire [`ICR_AW-1:0] regAddr,
    input wire [7:0]         regWdata,
    input wire [7:0]         regWmask,
    input wire               regWr,
    input wire               regRd,
    input wire [7:0]         regRdata,
    input wire               sclOe,
    input wire               sdaOe,
    input wire               coreWait,
    input wire               opEnable,
    input wire               startTrig,
    input wire               stopTrig,
    input wire               waitCancel,
    input wire               standby
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire c0w = regWr && regAddr == `ICR_ADDR_CTRL0;
    wire exw = c0w && regWmask[6] && regWdata[6];
    ////////////////////////////////////////////////////////////////////////////////
    property p_rd0;
        regRd && regAddr == `ICR_ADDR_CTRL0 |=> regRdata[6:5] == 2'b00;
    endproperty
    a_rd0: assert property (p_rd0) else $error("self-clear bits read high");
    property p_en;
        c0w && regWmask[7] |=> opEnable == $past(regWdata[7]);
    endproperty
    a_en: assert property (p_en) else $error("enable bit not taken");
    property p_st;
        regRd && regAddr == `ICR_ADDR_STATUS && !opEnable |=> regRdata == 8'h00;
    endproperty
    a_st: assert property (p_st) else $error("status not clear when off");
    property p_fl;
        regRd && regAddr == `ICR_ADDR_FLAG && !opEnable |=> regRdata[7:6] == 2'b00;
    endproperty
    a_fl: assert property (p_fl) else $error("flags not clear when off");
    property p_ex;
        exw && opEnable |=> standby && !sclOe && !sdaOe;
    endproperty
    a_ex: assert property (p_ex) else $error("exit did not release");
    property p_trg;
        exw && opEnable && regWmask == 8'h40 |=> !startTrig && !stopTrig;
    endproperty
    a_trg: assert property (p_trg) else $error("exit left a trigger");
    property p_off;
        exw && !opEnable && !standby |=> !standby;
    endproperty
    a_off: assert property (p_off) else $error("exit acted while off");
    property p_wc;
        waitCancel |-> $past(coreWait) ##1 !waitCancel;
    endproperty
    a_wc: assert property (p_wc) else $error("bad wait cancel pulse");
endmodule // icr_ctrl0_monitor

bind icr_ctrl0 icr_ctrl0_monitor u_icr_ctrl0_monitor (
    .mclk, .reset_n, .regAddr, .regWdata, .regWmask, .regWr, .regRd,
    .regRdata, .sclOe, .sdaOe, .coreWait, .opEnable, .startTrig,
    .stopTrig, .waitCancel, .standby
);

// >>> verification/icr_ctrl0_tb.sv
// Purpose: self-checking bench for icr_ctrl0
// Assumes: bus model holds the far side of the lines
// Notes:   read data checked from a queue by a watcher
`timescale 1ns/1ps
`include "icr_defines.vh"

module icr_ctrl0_tb;
    localparam [19:0] C0 = `ICR_ADDR_CTRL0;
    localparam [19:0] C1 = `ICR_ADDR_CTRL1;
    localparam [19:0] ST = `ICR_ADDR_STATUS;
    localparam [19:0] FL = `ICR_ADDR_FLAG;
    reg        mclk = 1'b0;
    reg        reset_n = 1'b0;
    reg [19:0] regAddr = 20'h0;
    reg [7:0]  regWdata = 8'h00;
    reg [7:0]  regWmask = 8'h00;
    reg        regWr = 1'b0;
    reg        regRd = 1'b0;
    reg [11:0] cin = 12'h000;
    reg        rdD = 1'b0;
    reg [7:0]  r;
    reg [7:0]  expQ[$];
    integer    errors = 0;
    integer    cmp_count = 0;
    integer    cyc = 0;
    integer    i;
    wire [7:0] regRdata;
    wire       sclIn, sclOe, sdaIn, sdaOe, opEnable, waitPointSel, ackEnable;
    wire       startTrig, stopTrig, waitCancel, standby, irq, sclOut, sdaOut;

    icr_ctrl0 u_icr_ctrl0 (
        .mclk, .reset_n, .regAddr, .regWdata, .regWmask, .regWr, .regRd,
        .regRdata, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut, .sdaOe,
        .coreSclLow(cin[11]), .coreSdaLow(cin[10]), .coreWait(cin[9]),
        .coreNinth(cin[8]), .coreMasterSet(cin[7]), .coreTrcSet(cin[6]),
        .coreAckDet(cin[5]), .coreAddrMatch(cin[4]), .coreExtCode(cin[3]),
        .coreStartDone(cin[2]), .coreStopDone(cin[1]), .coreCollision(cin[0]),
        .opEnable, .waitPointSel, .ackEnable, .startTrig, .stopTrig,
        .waitCancel, .standby, .irq
    );
    icr_bus_model u_icr_bus_model (.sclOe, .sdaOe, .sclIn, .sdaIn);

    always #12.5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input [7:0] e, input [7:0] g);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("[FAIL] %0s exp %h got %h", nm, e, g);
            end
        end
    endtask

    task summarize;
        begin
            $display("compares %0d mismatches %0d", cmp_count, errors);
            if (errors == 0 && cmp_count > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    task tick(input integer n);
        begin
            repeat (n) @(posedge mclk);
            #1;
        end
    endtask

    task wr(input [19:0] a, input [7:0] d, input [7:0] m);
        begin
            @(posedge mclk);
            regAddr <= a;
            regWdata <= d;
            regWmask <= m;
            regWr <= 1'b1;
            @(posedge mclk);
            regWr <= 1'b0;
        end
    endtask

    task rd(input [19:0] a, input [7:0] e);
        begin
            @(posedge mclk);
            expQ.push_back(e);
            regAddr <= a;
            regRd <= 1'b1;
            @(posedge mclk);
            regRd <= 1'b0;
        end
    endtask

    task pulse(input [11:0] p);
        begin
            @(posedge mclk);
            cin <= cin | p;
            @(posedge mclk);
            cin <= cin & ~p;
        end
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (rdD)
            chk("rdata", expQ.pop_front(), regRdata);
        rdD <= regRd;
        if (cyc > 20000) begin
            errors = errors + 1;
            summarize;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        r = $urandom(32'h65E17735);
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        rd(C0, 8'h00);
        rd(20'hF0250, 8'h00);
        r = $urandom;
        wr(C0, {3'b111, r[4:0]}, 8'hFF);
        wr(C0, {6'h00, r[1:0]}, 8'h03);
        rd(C0, {3'b100, r[4:0]});
        tick(1);
        chk("standby", 0, standby);
        chk("waitpt", r[3], waitPointSel);
        chk("ack", r[2], ackEnable);
        chk("start", r[1], startTrig);
        chk("stop", r[0], stopTrig);
        pulse(12'h006);
        tick(1);
        chk("start", 0, startTrig);
        chk("stop", 0, stopTrig);
        $display("test enable done");
        for (i = 0; i < 3; i = i + 1) begin
            wr(C0, 8'h00, 8'hFF);
            wr(C1, {i == 2, 7'h00}, 8'hFF);
            wr(C0, {3'b100, i != 1, 4'h0}, 8'hFF);
            wr(`ICR_ADDR_IRQEN, 8'h01, 8'hFF);
            wr(`ICR_ADDR_IRQCLR, 8'h07, 8'hFF);
            wr(C0, 8'h03, 8'h03);
            wr(C0, 8'h40, 8'h40);
            tick(1);
            chk("standby", 1, standby);
            chk("trig", 0, {startTrig, stopTrig});
            u_icr_bus_model.genStart;
            u_icr_bus_model.genStop;
            tick(8);
            chk("standby", 0, standby);
            chk("irq", i == 0, irq);
            wr(`ICR_ADDR_IRQCLR, 8'h07, 8'hFF);
            tick(1);
            chk("irq", 0, irq);
        end
        $display("test exit and stop irq done");
        wr(C0, 8'h00, 8'hFF);
        wr(C0, 8'h80, 8'hFF);
        pulse(12'h040);
        rd(ST, 8'h08);
        @(posedge mclk);
        cin <= 12'hF00;
        tick(2);
        chk("scloe", 1, sclOe);
        chk("sdaoe", 1, sdaOe);
        wr(C0, 8'h20, 8'h20);
        i = 0;
        while (waitCancel !== 1'b1 && i < 10) begin
            tick(1);
            i = i + 1;
        end
        chk("waitcancel", 1, waitCancel);
        tick(1);
        chk("sdaoe", 0, sdaOe);
        rd(ST, 8'h00);
        rd(C0, 8'h80);
        @(posedge mclk);
        cin <= 12'h000;
        $display("test wait release done");
        tick(4);
        rd(C1, 8'hB0);
        u_icr_bus_model.genStart;
        tick(6);
        pulse(12'h001);
        rd(FL, 8'hC0);
        wr(C0, 8'h00, 8'hFF);
        rd(ST, 8'h00);
        rd(FL, 8'h00);
        u_icr_bus_model.genStop;
        rd(C1, 8'h80);
        $display("test disable done");
        wr(C1, 8'h04, 8'hFF);
        u_icr_bus_model.holdSda(1'b0);
        tick(4);
        wr(C0, 8'h80, 8'hFF);
        pulse(12'h0F8);
        rd(ST, 8'hEE);
        wr(C0, 8'h40, 8'h40);
        rd(ST, 8'h00);
        tick(1);
        chk("standby", 1, standby);
        u_icr_bus_model.holdSda(1'b1);
        tick(8);
        chk("standby", 0, standby);
        chk("sclout", 0, sclOut);
        chk("sdaout", 0, sdaOut);
        $display("test spurious start done");
        summarize;
    end
endmodule // icr_ctrl0_tb
